/* camd_chk_sva.sv */
// port assertions for the decoder
`timescale 1ns/100ps
module camd_chk (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               start,
  input wire logic [7:0]         index_x,
  input wire logic [7:0]         index_y,
  input camd_pkg::camd_mem_req_t mem_req,
  input wire logic               mem_ack,
  input camd_pkg::camd_result_t  result,
  input wire logic               busy,
  input wire logic [6:0]         instr_count,
  input wire logic [3:0]         group_count
);
  import camd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  reset_clear_a: assert property (disable iff (1'b0) !nrst |=> !busy && !result.valid)
    else $error("outputs not cleared by reset");
  start_busy_a: assert property (start && !busy |=> busy)
    else $error("start in idle ignored");
  decode_bound_a: assert property ($rose(busy) |-> ##[3:200] result.valid)
    else $error("decode never finished");
  valid_pulse_a: assert property (result.valid |=> !result.valid)
    else $error("valid longer than one cycle");
  req_hold_a: assert property (mem_req.req && !mem_ack |=> mem_req.req && $stable(mem_req.addr))
    else $error("request dropped before ack");
  illegal_zero_a: assert property (result.valid && result.illegal |-> result.ea == 16'h0000)
    else $error("illegal encoding has address");
  page_zero_a: assert property (result.valid && result.mode inside {CAMD_M_DIR_S, CAMD_M_IND_S}
    |-> result.ea[15:8] == 8'h00)
    else $error("short address off page zero");
  no_offset_a: assert property (result.valid && result.mode == CAMD_M_IDX_0
    |-> result.ea == {8'h00, result.use_y ? index_y : index_x})
    else $error("no offset address wrong");
  short_index_a: assert property (result.valid && result.mode inside {CAMD_M_IDX_S, CAMD_M_IIX_S}
    |-> result.ea <= 16'h01FE)
    else $error("short indexed beyond 1FE");
  count_const_a: assert property (instr_count == 7'h3F && group_count == 4'hD)
    else $error("instruction counts wrong");
endmodule : camd_chk

bind camd_decoder camd_chk i_chk (.clk(clk), .nrst(nrst), .start(start), .index_x(index_x),
  .index_y(index_y), .mem_req(mem_req), .mem_ack(mem_ack), .result(result), .busy(busy),
  .instr_count(instr_count), .group_count(group_count));

/* camd_decoder.sv */
// instruction fetch and effective-address decoder
`timescale 1ns/100ps
`include "camd_defs.svh"

module camd_decoder (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               start,
  input  wire logic [15:0]        start_pc,
  input  wire logic [7:0]         index_x,
  input  wire logic [7:0]         index_y,
  output camd_pkg::camd_mem_req_t mem_req,
  input  wire logic               mem_ack,
  input  wire logic [7:0]         mem_rdata,
  output camd_pkg::camd_result_t  result,
  output logic [15:0]             next_pc_out,
  output logic                    busy,
  output logic [6:0]              instr_count,
  output logic [3:0]              group_count
);
  import camd_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [3:0] {
    CAMD_S_IDLE, CAMD_S_OPC, CAMD_S_B1, CAMD_S_B2, CAMD_S_PTR_LO,
    CAMD_S_PTR_HI, CAMD_S_DONE
  } camd_state_t;

  camd_state_t  state;
  logic [15:0]  pc;
  logic [15:0]  fetch_addr;
  logic [7:0]   opcode;
  logic [7:0]   prebyte;
  logic [7:0]   byte1;
  logic [7:0]   byte2;
  logic [7:0]   ptr_hi;
  camd_mode_t   mode;
  logic         use_y;
  logic         illegal;
  camd_result_t res;
  logic [15:0]  npc;

  // ----------------------------------------
  // opcode classification
  // ----------------------------------------
  camd_mode_t   base_mode;
  camd_mode_t   eff_mode;
  logic         eff_y;
  logic         eff_bad;
  logic         short_only;
  logic [3:0]   hi_nib;
  logic [3:0]   lo_nib;

  assign hi_nib = opcode[`CAMD_OPMODE_LO:`CAMD_OPMODE_HI];
  assign lo_nib = opcode[`CAMD_OPLOW_LO:`CAMD_OPLOW_HI];

  // base mode of the unprefixed X/direct opcode
  always_comb
  begin
    short_only = 1'b0;
    case (hi_nib)
      4'hA: base_mode = (lo_nib == 4'hD) ? CAMD_M_REL_D : CAMD_M_IMM;
      4'hB: base_mode = CAMD_M_DIR_S;
      4'hC: base_mode = CAMD_M_DIR_L;
      4'hD: base_mode = CAMD_M_IDX_L;
      4'hE: base_mode = CAMD_M_IDX_S;
      4'hF: base_mode = CAMD_M_IDX_0;
      4'h2: base_mode = CAMD_M_REL_D;
      4'h3:
      begin
        base_mode  = CAMD_M_DIR_S;
        short_only = 1'b1;
      end
      4'h6:
      begin
        base_mode  = CAMD_M_IDX_S;
        short_only = 1'b1;
      end
      4'h7:
      begin
        base_mode  = CAMD_M_IDX_0;
        short_only = 1'b1;
      end
      default: base_mode = CAMD_M_INH;
    endcase
  end

  // prebyte conversion
  always_comb
  begin
    eff_mode = base_mode;
    eff_y    = 1'b0;
    eff_bad  = 1'b0;
    case (prebyte)
      `CAMD_PRE_Y:
      begin
        eff_y   = 1'b1;
        eff_bad = (base_mode == CAMD_M_DIR_L) || (base_mode == CAMD_M_REL_D);
      end
      `CAMD_PRE_IND:
      begin
        case (base_mode)
          CAMD_M_DIR_S: eff_mode = CAMD_M_IND_S;
          CAMD_M_DIR_L: eff_mode = CAMD_M_IND_L;
          CAMD_M_REL_D: eff_mode = CAMD_M_REL_I;
          CAMD_M_IDX_S: eff_mode = CAMD_M_IIX_S;
          CAMD_M_IDX_L: eff_mode = CAMD_M_IIX_L;
          default:      eff_bad  = 1'b1;
        endcase
        if (short_only && base_mode == CAMD_M_DIR_L)
          eff_bad = 1'b1;
      end
      `CAMD_PRE_YIND:
      begin
        eff_y = 1'b1;
        case (base_mode)
          CAMD_M_IDX_S: eff_mode = CAMD_M_IIX_S;
          CAMD_M_IDX_L: eff_mode = CAMD_M_IIX_L;
          default:      eff_bad  = 1'b1;
        endcase
      end
      default: ;
    endcase
  end

  // ----------------------------------------
  // address arithmetic
  // ----------------------------------------
  logic [7:0]  index_sel;
  logic [15:0] ptr_word;
  logic [15:0] rel_base;
  logic [7:0]  rel_off;
  logic [15:0] ea_calc;

  assign index_sel = use_y ? index_y : index_x;
  // word pointers high byte first
  assign ptr_word  = {ptr_hi, byte2};
  assign rel_base  = pc;
  assign rel_off   = (mode == CAMD_M_REL_I) ? byte2 : byte1;

  always_comb
  begin
    case (mode)
      CAMD_M_DIR_S: ea_calc = {`CAMD_HI_ZERO, byte1};
      CAMD_M_DIR_L: ea_calc = {byte1, byte2};
      CAMD_M_IDX_0: ea_calc = {`CAMD_HI_ZERO, index_sel};
      CAMD_M_IDX_S: ea_calc = {`CAMD_HI_ZERO, byte1} + {`CAMD_HI_ZERO, index_sel};
      CAMD_M_IDX_L: ea_calc = {byte1, byte2} + {`CAMD_HI_ZERO, index_sel};
      CAMD_M_IND_S: ea_calc = {`CAMD_HI_ZERO, byte2};
      CAMD_M_IND_L: ea_calc = ptr_word;
      CAMD_M_IIX_S: ea_calc = {`CAMD_HI_ZERO, byte2} + {`CAMD_HI_ZERO, index_sel};
      CAMD_M_IIX_L: ea_calc = ptr_word + {`CAMD_HI_ZERO, index_sel};
      CAMD_M_REL_D, CAMD_M_REL_I:
        ea_calc = rel_base + {{`CAMD_SEXT_W{rel_off[`CAMD_SIGN_BIT]}}, rel_off};
      default:      ea_calc = pc;
    endcase
  end

  // ----------------------------------------
  // fetch sequencer
  // ----------------------------------------
  logic is_ptr_mode;
  logic two_operand;
  assign is_ptr_mode = (mode == CAMD_M_IND_S) || (mode == CAMD_M_IND_L) ||
                       (mode == CAMD_M_IIX_S) || (mode == CAMD_M_IIX_L) ||
                       (mode == CAMD_M_REL_I);
  assign two_operand = (mode == CAMD_M_DIR_L) || (mode == CAMD_M_IDX_L);
  logic ptr_word_mode;
  assign ptr_word_mode = (mode == CAMD_M_IND_L) || (mode == CAMD_M_IIX_L);
  // decoded modes that need no operand byte
  logic no_operand;
  assign no_operand = eff_bad || (eff_mode == CAMD_M_INH) || (eff_mode == CAMD_M_IDX_0);

  // ----------------------------------------
  // prebyte recognition
  // ----------------------------------------
  // second prebyte falls through as opcode
  logic is_prefix;
  logic first_prefix;
  assign is_prefix    = (mem_rdata == `CAMD_PRE_Y) || (mem_rdata == `CAMD_PRE_IND) ||
                        (mem_rdata == `CAMD_PRE_YIND);
  assign first_prefix = is_prefix && (prebyte == `CAMD_HI_ZERO);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state      <= CAMD_S_IDLE;
      pc         <= `CAMD_PC_RESET;
      fetch_addr <= `CAMD_PC_RESET;
      opcode     <= `CAMD_HI_ZERO;
      prebyte    <= `CAMD_HI_ZERO;
      byte1      <= `CAMD_HI_ZERO;
      byte2      <= `CAMD_HI_ZERO;
      ptr_hi     <= `CAMD_HI_ZERO;
      mode       <= CAMD_M_INH;
      use_y      <= 1'b0;
      illegal    <= 1'b0;
    end
    else
    begin
      case (state)
        CAMD_S_IDLE:
          if (start)
          begin
            pc      <= start_pc;
            prebyte <= `CAMD_HI_ZERO;
            state   <= CAMD_S_OPC;
          end
        CAMD_S_OPC:
          if (mem_ack)
          begin
            pc <= pc + `CAMD_ONE;
            if (first_prefix)
              prebyte <= mem_rdata;
            else
            begin
              opcode <= mem_rdata;
              state  <= CAMD_S_B1;
              mode   <= CAMD_M_ILLEGAL;
            end
          end
        CAMD_S_B1:
          // first cycle after opcode latches decode with no fetch; later cycles fetch operand byte
          if (mode == CAMD_M_ILLEGAL)
          begin
            mode    <= eff_bad ? CAMD_M_ILLEGAL : eff_mode;
            use_y   <= eff_y;
            illegal <= eff_bad;
            if (no_operand)
              state <= CAMD_S_DONE;
          end
          else if (mem_ack)
          begin
            pc    <= pc + `CAMD_ONE;
            byte1 <= mem_rdata;
            if (two_operand)
              state <= CAMD_S_B2;
            else if (is_ptr_mode)
            begin
              fetch_addr <= {`CAMD_HI_ZERO, mem_rdata};
              state      <= ptr_word_mode ? CAMD_S_PTR_HI : CAMD_S_PTR_LO;
            end
            else
              state <= CAMD_S_DONE;
          end
        CAMD_S_B2:
          if (mem_ack)
          begin
            pc    <= pc + `CAMD_ONE;
            byte2 <= mem_rdata;
            state <= CAMD_S_DONE;
          end
        CAMD_S_PTR_HI:
          if (mem_ack)
          begin
            ptr_hi     <= mem_rdata;
            fetch_addr <= fetch_addr + `CAMD_ONE;
            state      <= CAMD_S_PTR_LO;
          end
        CAMD_S_PTR_LO:
          if (mem_ack)
          begin
            byte2 <= mem_rdata;
            state <= CAMD_S_DONE;
          end
        CAMD_S_DONE:
          state <= CAMD_S_IDLE;
        default:
          state <= CAMD_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      res <= '0;
      npc <= `CAMD_PC_RESET;
    end
    else
    begin
      res.valid <= (state == CAMD_S_DONE);
      if (state == CAMD_S_DONE)
      begin
        res.opcode  <= opcode;
        res.use_y   <= use_y;
        res.mode    <= mode;
        // illegal encodings report no address
        res.ea      <= illegal ? `CAMD_PC_RESET : ea_calc;
        res.illegal <= illegal;
        npc         <= pc;
      end
    end
  end

  // ----------------------------------------
  // memory request and outputs
  // ----------------------------------------
  // request is combinational, held until ack
  logic mem_phase;
  assign mem_phase = (state == CAMD_S_OPC) || (state == CAMD_S_B2) ||
                     (state == CAMD_S_PTR_HI) || (state == CAMD_S_PTR_LO) ||
                     ((state == CAMD_S_B1) && (mode != CAMD_M_ILLEGAL));

  assign mem_req.req  = mem_phase;
  assign mem_req.addr = (state == CAMD_S_PTR_HI || state == CAMD_S_PTR_LO) ?
                        fetch_addr : pc;
  assign result       = res;
  assign next_pc_out  = npc;
  assign busy         = (state != CAMD_S_IDLE);
  assign instr_count  = `CAMD_INSTR_CNT;
  assign group_count  = `CAMD_GROUP_CNT;
endmodule : camd_decoder

/* camd_decoder_test.sv */
// self-checking bench for the decoder
`timescale 1ns/100ps
module camd_decoder_test;
  import camd_pkg::*;
  logic          clk = 1'b0;
  logic          nrst = 1'b0;
  logic          start = 1'b0;
  logic          slow = 1'b0;
  logic [15:0]   start_pc = 16'h0000;
  logic [7:0]    index_x = 8'h00;
  logic [7:0]    index_y = 8'h00;
  logic [15:0]   rnd = 16'hC24E;
  logic [15:0]   b;
  logic [7:0]    pv [4] = '{8'h00, 8'h90, 8'h92, 8'h91};
  logic [3:0]    hv [8] = '{4'h2, 4'h8, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  logic          mem_ack;
  logic [7:0]    mem_rdata;
  logic [15:0]   next_pc_out;
  logic          busy;
  logic [6:0]    instr_count;
  logic [3:0]    group_count;
  camd_mem_req_t mem_req;
  camd_result_t  result;
  int            fail_count = 0;
  int            cmp_count = 0;
  int            cyc = 0;

  always #2.5 clk = ~clk;

  camd_decoder i_camd_decoder (.clk(clk), .nrst(nrst), .start(start), .start_pc(start_pc),
    .index_x(index_x), .index_y(index_y), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .result(result), .next_pc_out(next_pc_out), .busy(busy),
    .instr_count(instr_count), .group_count(group_count));
  camd_mem_model i_camd_mem_model (.clk(clk), .slow(slow), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  function automatic void lfsr_step();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
  endfunction : lfsr_step

  function automatic logic [7:0] rd(input logic [15:0] a);
    return i_camd_mem_model.mem[a];
  endfunction : rd

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic run(input logic [7:0] pre, input logic [7:0] op, input logic [7:0] b1,
                     input logic [7:0] b2, input logic [7:0] x, input logic [7:0] y);
    logic [15:0] pc;
    logic [15:0] p;
    logic [15:0] ea;
    logic        ind;
    logic        uy;
    logic        bad;
    int          n;
    camd_mode_t  md;
    lfsr_step();
    pc = {2'b01, rnd[13:0]};
    p = pc;
    if (pre != 8'h00)
    begin
      i_camd_mem_model.mem[p] = pre;
      p = p + 16'h1;
    end
    i_camd_mem_model.mem[p] = op;
    p = p + 16'h1;
    i_camd_mem_model.mem[p] = b1;
    i_camd_mem_model.mem[p + 16'h1] = b2;
    // expected decode of the instruction
    ind = pre == 8'h92 || pre == 8'h91;
    uy = pre == 8'h90 || pre == 8'h91;
    n = 1;
    ea = {8'h00, b1};
    case (op[7:4])
      4'hA: md = op == 8'hAD ? CAMD_M_REL_D : CAMD_M_IMM;
      4'hB, 4'h3: md = ind ? CAMD_M_IND_S : CAMD_M_DIR_S;
      4'hC: md = ind ? CAMD_M_IND_L : CAMD_M_DIR_L;
      4'hD: md = ind ? CAMD_M_IIX_L : CAMD_M_IDX_L;
      4'hE, 4'h6: md = ind ? CAMD_M_IIX_S : CAMD_M_IDX_S;
      4'hF, 4'h7: md = CAMD_M_IDX_0;
      4'h2: md = ind ? CAMD_M_REL_I : CAMD_M_REL_D;
      default: md = CAMD_M_INH;
    endcase
    if (md inside {CAMD_M_INH, CAMD_M_IDX_0}) n = 0;
    if (md inside {CAMD_M_DIR_L, CAMD_M_IDX_L}) n = 2;
    if (md inside {CAMD_M_DIR_L, CAMD_M_IDX_L}) ea = {b1, b2};
    if (md inside {CAMD_M_IND_S, CAMD_M_IIX_S, CAMD_M_REL_I}) ea = {8'h00, rd(ea)};
    if (md inside {CAMD_M_IND_L, CAMD_M_IIX_L}) ea = {rd(ea), rd(ea + 16'h1)};
    if (md inside {CAMD_M_IDX_S, CAMD_M_IDX_L, CAMD_M_IIX_S, CAMD_M_IIX_L}) ea = ea + (uy ? y : x);
    if (md == CAMD_M_IDX_0) ea = {8'h00, uy ? y : x};
    p = p + n[15:0];
    if (md inside {CAMD_M_REL_D, CAMD_M_REL_I}) ea = p + {{8{ea[7]}}, ea[7:0]};
    bad = (pre == 8'h90 && op[7:4] inside {4'hC, 4'h2});
    bad = bad || (pre == 8'h92 && !(op[7:4] inside {4'hB, 4'hC, 4'hD, 4'hE, 4'h2, 4'h3, 4'h6}));
    bad = bad || (pre == 8'h91 && !(op[7:4] inside {4'hD, 4'hE, 4'h6}));
    @(negedge clk);
    slow = rnd[3];
    index_x = x;
    index_y = y;
    start_pc = pc;
    start = 1'b1;
    @(negedge clk);
    // start held into busy must be ignored
    start = rnd[5];
    @(negedge clk);
    start = 1'b0;
    for (n = 0; n < 300 && result.valid !== 1'b1; n++)
      @(negedge clk);
    chk("valid", result.valid, 1'b1);
    chk("illegal", result.illegal, bad);
    if (bad)
      chk("illegal ea", result.ea, 16'h0000);
    else
    begin
      chk("mode", result.mode, md);
      chk("opcode index", {result.opcode, result.use_y}, {op, uy});
      chk("next pc", next_pc_out, p);
      if (!(md inside {CAMD_M_IMM, CAMD_M_INH}))
        chk("ea", result.ea, ea);
    end
  endtask : run

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    for (int a = 0; a < 256; a++)
    begin
      lfsr_step();
      i_camd_mem_model.mem[a] = rnd[7:0];
    end
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    chk("instr count", instr_count, 7'h3F);
    chk("group count", group_count, 4'hD);
    run(8'h00, 8'hE0, 8'hFF, 8'h00, 8'hFF, 8'h00);
    run(8'h90, 8'hE0, 8'hFF, 8'h00, 8'h00, 8'hFF);
    run(8'h00, 8'hAD, 8'h80, 8'h00, 8'h00, 8'h00);
    run(8'h91, 8'h80, 8'h10, 8'h00, 8'h00, 8'h00);
    run(8'h92, 8'h3A, 8'h20, 8'h00, 8'h00, 8'h00);
    run(8'h91, 8'h6C, 8'h30, 8'h00, 8'h00, 8'h80);
    run(8'h90, 8'h7C, 8'h00, 8'h00, 8'h11, 8'h42);
    run(8'h92, 8'h7C, 8'h00, 8'h00, 8'h11, 8'h42);
    for (int i = 0; i < 300; i++)
    begin
      lfsr_step();
      b = rnd;
      lfsr_step();
      run(pv[b[1:0]], {hv[b[4:2]], b[8:5] == 4'hD ? 4'hC : b[8:5]},
          b[1] ? (rnd[7:0] & 8'h7E) : rnd[7:0], rnd[15:8], b[15:8], rnd[11:4]);
    end
    stop_test();
  end
endmodule : camd_decoder_test

/* camd_defs.svh */
// constants for the addressing mode decoder
`ifndef CAMD_DEFS_SVH
`define CAMD_DEFS_SVH
`define CAMD_PRE_Y      8'h90
`define CAMD_PRE_IND    8'h92
`define CAMD_PRE_YIND   8'h91
`define CAMD_ADDR_W     16
`define CAMD_PC_RESET   16'h0000
`define CAMD_INSTR_CNT  7'h3F
`define CAMD_GROUP_CNT  4'hD
`define CAMD_HI_ZERO    8'h00
`define CAMD_ONE        16'h0001
`define CAMD_OPMODE_HI  4
`define CAMD_OPMODE_LO  7
`define CAMD_OPLOW_HI   0
`define CAMD_OPLOW_LO   3
`define CAMD_SIGN_BIT   7
`define CAMD_SEXT_W     8
`endif

/* camd_mem_model.sv */
// byte memory answering the decoder's reads
`timescale 1ns/100ps
module camd_mem_model (
  input  wire logic               clk,
  input  wire logic               slow,
  input  camd_pkg::camd_mem_req_t mem_req,
  output logic                    mem_ack,
  output logic [7:0]              mem_rdata
);
  import camd_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  logic [1:0] dly  = 2'h0;
  // slow mode answers every fourth cycle
  assign mem_ack = mem_req.req && (!slow || dly == 2'h3);
  // released bus shows the inverse of the last byte
  assign mem_rdata = mem_ack ? mem[mem_req.addr] : ~last;
  always_ff @(posedge clk)
  begin
    dly <= dly + 2'h1;
    if (mem_ack)
      last <= mem[mem_req.addr];
  end
endmodule : camd_mem_model

/* camd_pkg.sv */
// types for the addressing mode decoder
package camd_pkg;
  typedef enum logic [3:0] {
    CAMD_M_INH, CAMD_M_IMM, CAMD_M_DIR_S, CAMD_M_DIR_L, CAMD_M_IDX_0,
    CAMD_M_IDX_S, CAMD_M_IDX_L, CAMD_M_IND_S, CAMD_M_IND_L, CAMD_M_IIX_S,
    CAMD_M_IIX_L, CAMD_M_REL_D, CAMD_M_REL_I, CAMD_M_ILLEGAL
  } camd_mode_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic        use_y;
    camd_mode_t  mode;
    logic [15:0] ea;
    logic        illegal;
  } camd_result_t;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } camd_mem_req_t;
endpackage : camd_pkg
